// [spm_mux.sv]
// shared pin multiplexer and general i/o for ports a, b and c
`timescale 1ns/1ps
`include "spm_regs.svh"
module spm_mux (
  input wire logic CLK, // 10 mhz core clock
  input wire logic RST_N, // async reset, active low
  input wire logic [15:0] ADDR, // data space address
  input wire logic [15:0] WDATA, // write data
  input wire logic WE, // write strobe
  input wire logic RE, // read strobe
  output logic [15:0] RDATA, // registered read data
  input wire logic [1:0] CLOCK_OUT_SELECT_FIELD, // system control register bits 7-6
  input wire logic [2:0] CLK_SRC, // the three clock output sources
  input wire logic [3:0] PA_IN, // port a pin levels
  output logic [3:0] PA_OUT, // port a pin drive
  output logic [3:0] PA_OE, // port a pin enable
  input wire logic [7:0] PB_IN, // port b pin levels
  output logic [7:0] PB_OUT, // port b pin drive
  output logic [7:0] PB_OE, // port b pin enable
  input wire logic [7:0] PC_IN, // port c pin levels
  output logic [7:0] PC_OUT, // port c pin drive
  output logic [7:0] PC_OE, // port c pin enable
  input wire logic [3:0] PA_PERIPH_OUT, // peripheral value for port a pins
  input wire logic [3:0] PA_PERIPH_OE, // peripheral enable for port a pins
  output logic [3:0] PA_TO_PERIPH, // port a levels to analog inputs
  input wire logic [7:0] PB_PERIPH_OUT, // compare outputs and timer pins
  input wire logic [7:0] PB_PERIPH_OE, // their enables
  output logic [7:0] PB_TO_PERIPH, // port b levels to peripherals
  input wire logic [7:0] PC_PERIPH_OUT, // port c peripheral values incl. cpu flag
  input wire logic [7:0] PC_PERIPH_OE, // their enables
  output logic [7:0] PC_TO_PERIPH // port c levels incl. branch input, capture
);
  // -------------------------------------------------------------
  // registers
  // -------------------------------------------------------------
  logic [15:0] mux_ctrl_a;
  logic [15:0] mux_ctrl_b;
  logic [15:0] port_a;
  logic [15:0] port_b;
  logic [15:0] port_c;
  // serial, spi and external interrupt pins have no path here
  wire hit_ma = (ADDR == `SPM_ADDR_MUX_CTRL_A);
  wire hit_mb = (ADDR == `SPM_ADDR_MUX_CTRL_B);
  wire hit_pa = (ADDR == `SPM_ADDR_PORT_A);
  wire hit_pb = (ADDR == `SPM_ADDR_PORT_B);
  wire hit_pc = (ADDR == `SPM_ADDR_PORT_C);
  wire [15:0] wmask_ma = WDATA & `SPM_MASK_MUX_CTRL_A;
  wire [15:0] wmask_mb = WDATA & `SPM_MASK_MUX_CTRL_B;
  wire [15:0] wmask_pa = WDATA & `SPM_MASK_PORT_A;
  wire [15:0] wmask_pb = WDATA & `SPM_MASK_PORT_B;
  wire [15:0] wmask_pc = WDATA & `SPM_MASK_PORT_C;
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      mux_ctrl_a <= `SPM_RST_MUX_CTRL;
      mux_ctrl_b <= `SPM_RST_MUX_CTRL;
      port_a <= `SPM_RST_PORT;
      port_b <= `SPM_RST_PORT;
      port_c <= `SPM_RST_PORT;
    end else if (WE) begin
      if (hit_ma) mux_ctrl_a <= wmask_ma;
      if (hit_mb) mux_ctrl_b <= wmask_mb;
      if (hit_pa) port_a <= wmask_pa;
      if (hit_pb) port_b <= wmask_pb;
      if (hit_pc) port_c <= wmask_pc;
    end
  end
  // -------------------------------------------------------------
  // pin selection
  // -------------------------------------------------------------
  // mux bit 1 hands the pin to the peripheral except the inverted c bits and pin c1
  wire [3:0] sel_a = mux_ctrl_a[3:0];
  wire [7:0] sel_b = mux_ctrl_a[`SPM_MUXA_PORT_B_LSB +: 8];
  wire [7:0] sel_c_raw = mux_ctrl_b[7:0] ^ `SPM_INV_POL_C;
  // pin c1 has no mux bit; it follows the clock select field instead
  spm_pkg::spm_clk_sel_t clk_sel;
  assign clk_sel = spm_pkg::spm_clk_sel_t'(CLOCK_OUT_SELECT_FIELD);
  wire c1_clk = (clk_sel != spm_pkg::SPM_CLK_GPIO);
  wire [7:0] sel_c = {sel_c_raw[7:2], c1_clk, sel_c_raw[0]};
  logic clk_src_val;
  always_comb begin
    case (clk_sel)
      spm_pkg::SPM_CLK_SRC1: clk_src_val = CLK_SRC[0];
      spm_pkg::SPM_CLK_SRC2: clk_src_val = CLK_SRC[1];
      spm_pkg::SPM_CLK_SRC3: clk_src_val = CLK_SRC[2];
      default: clk_src_val = 1'b0;
    endcase
  end
  wire [7:0] pc_pout = {PC_PERIPH_OUT[7:2], clk_src_val, PC_PERIPH_OUT[0]};
  wire [7:0] pc_poe = {PC_PERIPH_OE[7:2], 1'b1, PC_PERIPH_OE[0]};
  wire [3:0] na_out;
  wire [3:0] na_oe;
  wire [3:0] na_tp;
  wire [3:0] rd_a;
  wire [7:0] nb_out;
  wire [7:0] nb_oe;
  wire [7:0] nb_tp;
  wire [7:0] rd_b;
  wire [7:0] nc_out;
  wire [7:0] nc_oe;
  wire [7:0] nc_tp;
  wire [7:0] rd_c;
  spm_port #(.W(4)) u_port_a (
    .sel_periph(sel_a),
    .dat(port_a[3:0]),
    .dir(port_a[`SPM_DIR_LSB +: 4]),
    .periph_out(PA_PERIPH_OUT),
    .periph_oe(PA_PERIPH_OE),
    .pin_in(PA_IN),
    .next_out(na_out),
    .next_oe(na_oe),
    .next_to_periph(na_tp),
    .rd_data(rd_a)
  );
  spm_port #(.W(8)) u_port_b (
    .sel_periph(sel_b),
    .dat(port_b[7:0]),
    .dir(port_b[`SPM_DIR_LSB +: 8]),
    .periph_out(PB_PERIPH_OUT),
    .periph_oe(PB_PERIPH_OE),
    .pin_in(PB_IN),
    .next_out(nb_out),
    .next_oe(nb_oe),
    .next_to_periph(nb_tp),
    .rd_data(rd_b)
  );
  spm_port #(.W(8)) u_port_c (
    .sel_periph(sel_c),
    .dat(port_c[7:0]),
    .dir(port_c[`SPM_DIR_LSB +: 8]),
    .periph_out(pc_pout),
    .periph_oe(pc_poe),
    .pin_in(PC_IN),
    .next_out(nc_out),
    .next_oe(nc_oe),
    .next_to_periph(nc_tp),
    .rd_data(rd_c)
  );
  // -------------------------------------------------------------
  // read path
  // -------------------------------------------------------------
  // unmapped addresses read zero; illegal-address reset lives elsewhere
  wire [15:0] next_rdata =
    hit_ma ? mux_ctrl_a :
    hit_mb ? mux_ctrl_b :
    hit_pa ? {4'h0, port_a[11:8], 4'h0, rd_a} :
    hit_pb ? {port_b[15:8], rd_b} :
    hit_pc ? {port_c[15:8], rd_c} : 16'h0000;
  // -------------------------------------------------------------
  // registered outputs
  // -------------------------------------------------------------
  // outputs lag one cycle so every port leaves a flip-flop
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      RDATA <= 16'h0000;
      PA_OUT <= 4'h0;
      PA_OE <= 4'h0;
      PA_TO_PERIPH <= 4'h0;
      PB_OUT <= 8'h00;
      PB_OE <= 8'h00;
      PB_TO_PERIPH <= 8'h00;
      PC_OUT <= 8'h00;
      PC_OE <= 8'h00;
      PC_TO_PERIPH <= 8'h00;
    end else begin
      RDATA <= RE ? next_rdata : 16'h0000;
      PA_OUT <= na_out;
      PA_OE <= na_oe;
      PA_TO_PERIPH <= na_tp;
      PB_OUT <= nb_out;
      PB_OE <= nb_oe;
      PB_TO_PERIPH <= nb_tp;
      PC_OUT <= nc_out;
      PC_OE <= nc_oe;
      PC_TO_PERIPH <= nc_tp;
    end
  end
endmodule : spm_mux

// [spm_regs.svh]
// register offsets, field positions and reset values of the shared pin mux
`ifndef SPM_REGS_SVH
`define SPM_REGS_SVH
`define SPM_ADDR_MUX_CTRL_A 16'h7090
`define SPM_ADDR_MUX_CTRL_B 16'h7092
`define SPM_ADDR_PORT_A 16'h7098
`define SPM_ADDR_PORT_B 16'h709a
`define SPM_ADDR_PORT_C 16'h709c
`define SPM_RST_MUX_CTRL 16'h0000
`define SPM_RST_PORT 16'h0000
`define SPM_MASK_MUX_CTRL_A 16'hff0f
`define SPM_MASK_MUX_CTRL_B 16'h00fd
`define SPM_MASK_PORT_A 16'h0f0f
`define SPM_MASK_PORT_B 16'hffff
`define SPM_MASK_PORT_C 16'hffff
`define SPM_INV_POL_C 8'h0c
`define SPM_DIR_LSB 8
`define SPM_MUXA_PORT_B_LSB 8
`define SPM_CLOCK_OUTPUT_PIN_PIN 1
`endif

// [spm_pkg.sv]
// types shared by the shared pin mux files
package spm_pkg;
  typedef enum logic [1:0] {
    SPM_CLK_GPIO = 2'b00,
    SPM_CLK_SRC1 = 2'b01,
    SPM_CLK_SRC2 = 2'b10,
    SPM_CLK_SRC3 = 2'b11
  } spm_clk_sel_t;
endpackage : spm_pkg

// [spm_port.sv]
// one general i/o port: per-pin mux between peripheral and port bit
`timescale 1ns/1ps
module spm_port #(
  parameter int W = 8
) (
  input wire logic [W-1:0] sel_periph, // 1 = peripheral owns pin
  input wire logic [W-1:0] dat, // port data bits
  input wire logic [W-1:0] dir, // 1 = output
  input wire logic [W-1:0] periph_out, // peripheral drive value
  input wire logic [W-1:0] periph_oe, // peripheral drive enable
  input wire logic [W-1:0] pin_in, // pin level
  output logic [W-1:0] next_out, // next pin value
  output logic [W-1:0] next_oe, // next pin enable
  output logic [W-1:0] next_to_periph, // next level toward peripheral
  output logic [W-1:0] rd_data // data field read back
);
  // port bits steer the pin only while general i/o is selected
  assign next_out = (sel_periph & periph_out) | (~sel_periph & dat);
  assign next_oe = (sel_periph & periph_oe) | (~sel_periph & dir);
  assign next_to_periph = sel_periph & pin_in;
  assign rd_data = (dir & dat) | (~dir & pin_in);
endmodule : spm_port

// [spm_pin_model.sv]
// board side of the shared pins
`timescale 1ns/1ps
module spm_pin_model (
  input wire logic [19:0] drive, // pin values from the block
  input wire logic [19:0] enable, // pin enables from the block
  input wire logic [19:0] board, // level held on undriven pins
  output logic [19:0] level // resolved pin level
);
  // a pin that nobody drives shows the board level, never the last drive
  assign level = (drive & enable) | (board & ~enable);
endmodule : spm_pin_model

// [spm_mux_monitor.sv]
// port checker for the shared pin mux
`timescale 1ns/1ps
module spm_mux_monitor (
  input wire logic CLK, // clock
  input wire logic RST_N, // reset
  input wire logic [15:0] ADDR, // seen
  input wire logic [15:0] WDATA, // seen
  input wire logic WE, // seen
  input wire logic RE, // seen
  input wire logic [15:0] RDATA, // seen
  input wire logic [1:0] CLOCK_OUT_SELECT_FIELD, // seen
  input wire logic [2:0] CLK_SRC, // seen
  input wire logic [3:0] PA_OUT, // seen
  input wire logic [3:0] PA_OE, // seen
  input wire logic [3:0] PA_PERIPH_OUT, // seen
  input wire logic [3:0] PA_PERIPH_OE, // seen
  input wire logic [7:0] PC_OUT, // seen
  input wire logic [7:0] PC_OE, // seen
  input wire logic [7:0] PC_PERIPH_OE // seen
);
  // ----------
  // mux shadows
  // ----------
  logic a0;
  logic b2;
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) {a0, b2} <= 2'b00;
    else begin
      if (WE && ADDR == 16'h7090) a0 <= WDATA[0];
      if (WE && ADDR == 16'h7092) b2 <= WDATA[2];
    end
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  a_rdata_idle: assert property (!RE |=> RDATA == 16'h0000) else $error("rdata idle");
  a_unmapped_zero: assert property (
    RE && !(ADDR inside {16'h7090, 16'h7092, 16'h7098, 16'h709a, 16'h709c})
    |=> RDATA == 16'h0000) else $error("unmapped read");
  a_reserved_b: assert property (
    RE && ADDR == 16'h7092 |=> (RDATA & 16'hff02) == 16'h0000)
    else $error("mux b reserved");
  // the register takes the write on one edge and the pin flop follows on the next
  a_port_drive: assert property (
    WE && ADDR == 16'h7098 && !a0 |=> ##1 PA_OE[0] == $past(WDATA[8], 2)
    && (!PA_OE[0] || PA_OUT[0] == $past(WDATA[0], 2))) else $error("pa0 drive");
  a_port_readback: assert property (
    (WE && ADDR == 16'h7098 && WDATA[11:8] == 4'hf) ##1 (RE && !WE && ADDR == 16'h7098)
    |=> RDATA == ($past(WDATA, 2) & 16'h0f0f)) else $error("pa readback");
  a_clock_out: assert property (
    CLOCK_OUT_SELECT_FIELD != 2'b00 |=> PC_OE[1]
    && PC_OUT[1] == $past(CLK_SRC[CLOCK_OUT_SELECT_FIELD - 2'd1])) else $error("clock pin");
  a_periph_owns: assert property (
    a0 |=> PA_OE[0] == $past(PA_PERIPH_OE[0])
    && PA_OUT[0] == $past(PA_PERIPH_OUT[0])) else $error("pa0 peripheral");
  a_flag_inverted: assert property (!b2 |=> PC_OE[2] == $past(PC_PERIPH_OE[2])) else $error("c2 flag");
  c_periph: cover property (a0 && PA_PERIPH_OE[0]);
  c_clock: cover property (CLOCK_OUT_SELECT_FIELD == 2'b11);
  c_read_c: cover property (RE && ADDR == 16'h709c);
endmodule : spm_mux_monitor
bind spm_mux spm_mux_monitor spm_mux_monitor_inst (.*);

// [tb.sv]
// self-checking bench for the shared pin mux
`timescale 1ns/1ps
module tb;
  logic CLK, RST_N, WE, RE;
  logic [15:0] ADDR, WDATA, RDATA;
  logic [1:0] CLOCK_OUT_SELECT_FIELD;
  logic [2:0] CLK_SRC;
  logic [3:0] PA_IN, PA_OUT, PA_OE, PA_PERIPH_OUT, PA_PERIPH_OE, PA_TO_PERIPH;
  logic [7:0] PB_IN, PB_OUT, PB_OE, PB_PERIPH_OUT, PB_PERIPH_OE, PB_TO_PERIPH;
  logic [7:0] PC_IN, PC_OUT, PC_OE, PC_PERIPH_OUT, PC_PERIPH_OE, PC_TO_PERIPH;
  logic [19:0] board;
  int miscompares = 0;
  int checks = 0;
  spm_mux spm_mux_inst (.*);
  spm_pin_model spm_pin_model_inst (.drive({PC_OUT, PB_OUT, PA_OUT}), .enable({PC_OE, PB_OE, PA_OE}),
    .board(board), .level({PC_IN, PB_IN, PA_IN}));
  // ----------
  // bus tasks
  // ----------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic idle(input int n);
    WE = 1'b0;
    RE = 1'b0;
    repeat (n) @(posedge CLK);
    #1;
  endtask : idle
  // strobes are left up so back-to-back writes never drop WE between them
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    {ADDR, WDATA, WE, RE} = {a, d, 2'b10};
    @(posedge CLK);
    #1;
  endtask : wr
  task automatic rd(input logic [15:0] a, input logic [15:0] exp, input string what);
    {ADDR, WE, RE} = {a, 2'b01};
    @(posedge CLK);
    #1;
    chk(RDATA, exp, what);
  endtask : rd
  // ----------
  // scenarios
  // ----------
  task automatic t_regs;
    logic [15:0] a[5] = '{16'h7090, 16'h7092, 16'h7098, 16'h709a, 16'h709c};
    logic [15:0] m[5] = '{16'hff0f, 16'h00fd, 16'h0f0f, 16'hffff, 16'hffff};
    // port a pins are inputs after reset, so their data field shows the board level
    logic [15:0] r[5] = '{16'h0000, 16'h0000, 16'h000a, 16'h0000, 16'h0000};
    for (int i = 0; i < 5; i++) begin
      rd(a[i], r[i], "reset value");
      wr(a[i], 16'hffff);
      rd(a[i], m[i], "masked readback");
    end
    wr(16'h7094, 16'hffff);
    rd(16'h7094, 16'h0000, "unmapped");
  endtask : t_regs
  task automatic t_gpio;
    wr(16'h7090, 16'h0000);
    wr(16'h7098, 16'h0305);
    idle(3);
    chk(16'({PA_OE, PA_OUT & PA_OE}), 16'h0031, "pa drive");
    rd(16'h7098, 16'h0309, "pa input read");
  endtask : t_gpio
  task automatic t_periph;
    {PA_PERIPH_OUT, PA_PERIPH_OE, PB_PERIPH_OUT, PB_PERIPH_OE} = {4'h6, 4'hf, 8'h5a, 8'hff};
    {PC_PERIPH_OUT, PC_PERIPH_OE} = {8'h04, 8'h0c};
    wr(16'h7090, 16'hff0f);
    wr(16'h709c, 16'h0000);
    wr(16'h7092, 16'h0000);
    idle(3);
    chk(16'({PA_OE, PA_OUT, PA_TO_PERIPH}), 16'h0f66, "pa peripheral");
    chk({PB_OE, PB_OUT}, 16'hff5a, "pb peripheral");
    chk(16'(PB_TO_PERIPH), 16'h005a, "pb to peripheral");
    chk({PC_OE, PC_OUT & 8'h0c}, 16'h0c04, "c2 c3 flag owned");
    chk(16'(PC_TO_PERIPH), 16'h0004, "pc to peripheral");
    wr(16'h7092, 16'h000c);
    idle(3);
    chk(16'(PC_OE), 16'h0000, "c2 c3 as inputs");
  endtask : t_periph
  task automatic t_clock_output_pin;
    CLK_SRC = 3'b101;
    for (int c = 0; c < 4; c++) begin
      CLOCK_OUT_SELECT_FIELD = 2'(c);
      idle(3);
      chk(16'({PC_OE[1], PC_OUT[1] & PC_OE[1]}), c == 0 ? 16'h0000 : 16'(2 + CLK_SRC[c - 1]), "clock pin");
    end
  endtask : t_clock_output_pin
  task automatic tally_and_finish;
    if (miscompares == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    CLK = 1'b0;
    forever #50 CLK = ~CLK;
  end
  initial begin
    {RST_N, WE, RE, ADDR, WDATA, CLOCK_OUT_SELECT_FIELD, CLK_SRC} = '0;
    {PA_PERIPH_OUT, PA_PERIPH_OE, PB_PERIPH_OUT, PB_PERIPH_OE, PC_PERIPH_OUT, PC_PERIPH_OE} = '0;
    board = 20'h0000a;
    repeat (8) @(posedge CLK);
    #1;
    RST_N = 1'b1;
    t_regs();
    t_gpio();
    t_periph();
    t_clock_output_pin();
    tally_and_finish();
  end
  initial begin
    #200000;
    miscompares++;
    tally_and_finish();
  end
endmodule : tb
